/* osc_switch_doze.sv */
// osc_switch_doze: register file, unlock keys, clock switch sequencer,
// doze ratio and rc postscaler / trim control.
// assumes an AXI4-Lite master on sys_clk and raw oscillator levels from pins.
//
// Behaviour
// RULE1: freeze bit plus monitor blocks selection changes
// RULE2: pll_settled shows lock for pll modes only
// RULE3: clock_fail_flag sets on detected clock failure
// RULE4: high drive selects high-power secondary circuit
// RULE5: secondary_osc_enable turns secondary oscillator on/off
// RULE6: switch_request starts switch, reads 1 pending
// RULE7: interrupt clears ratio_enable when recover_on_irq set
// RULE8: clock_ratio_sel is power-of-two ratio, resets 011
// RULE9: ratio_enable low forces ratio 1:1
// RULE10: rc_postscale divides rc clock, resets 001
// RULE11: rc_trim is a signed frequency offset
// RULE12: switching only when switch_enable_cfg is 0
// RULE13: switching disabled shows start_osc_cfg as current
// RULE14: upper byte needs 78h,9Ah keys first
// RULE15: lower byte needs 46h,57h keys first
// RULE16: request to same source aborts at once
// RULE17: valid switch start clears lock and fail
// RULE18: start target, wait crystal timer and lock
// RULE19: count ten new-clock cycles before changeover
// RULE20: completion clears request, copies new to current
// RULE21: stop old source except kept ones
// RULE22: software avoids direct pll-to-pll switches
// RULE23: three-bit source selection code meanings
// RULE24: unkeyed control byte writes are ignored
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module osc_switch_doze
  import osc_ctl_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // register bus
  input  wire axi_req_t   bus_req,
  output axi_rsp_t        bus_rsp,
  // oscillator side
  input  wire osc_pins_t  pins,
  output src_t            cur_osc,
  output run_t            osc_run,
  output logic            secondary_osc_high_power,
  output logic            switch_busy,
  // doze and rc control
  output logic [2:0]      ratio_code,
  output logic [2:0]      rc_post_code,
  output logic            rc_post_active,
  output logic [5:0]      rc_trim_out
);

  // two-flop synchroniser for every pin level
  osc_pins_t  pin_a_q;
  osc_pins_t  pin_s_q;
  logic       clk_d_q;
  logic [1:0] init_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_a_q <= '0;
      pin_s_q <= '0;
      clk_d_q <= 1'b0;
      init_q  <= 2'h0;
    end else begin
      pin_a_q <= pins;
      pin_s_q <= pin_a_q;
      clk_d_q <= pin_s_q.new_clk;
      if (init_q != INIT_CYCLES) init_q <= init_q + 2'h1;
    end
  end

  // configuration decode
  wire init_done = (init_q == INIT_CYCLES);
  wire init_load = (init_q == INIT_CYCLES - 2'h1);
  wire sw_enabled = ~pin_s_q.switch_enable_cfg; // see RULE12
  wire monitor_on = sw_enabled & ~pin_s_q.fail_safe_monitor_cfg;
  wire clk_edge   = pin_s_q.new_clk & ~clk_d_q;

  // bus state
  logic           aw_held_q;
  logic           w_held_q;
  logic [AW-1:0]  awaddr_q;
  logic [31:0]    wdata_q;
  logic [3:0]     wstrb_q;
  logic           bvalid_q;
  logic [1:0]     bresp_q;
  logic           rvalid_q;
  logic [31:0]    rdata_q;
  logic [1:0]     rresp_q;

  // control state
  src_t       cur_q;
  src_t       new_q;
  src_t       tgt_q;
  sw_state_t  state_q;
  key_state_t hi_key_q;
  key_state_t lo_key_q;
  key_state_t hi_key_d;
  key_state_t lo_key_d;
  logic       freeze_q;
  logic       lock_q;
  logic       cf_q;
  logic       drv_q;
  logic       secondary_osc_en_q;
  logic       req_q;
  logic [3:0] cnt_q;
  logic       roi_q;
  logic [2:0] ratio_sel_q;
  logic       ratio_en_q;
  logic [2:0] post_q;
  logic [5:0] trim_q;

  // write decode
  wire       wr_fire   = aw_held_q & w_held_q & ~bvalid_q;
  wire       wr_osc    = wr_fire & (awaddr_q == OSC_CTRL_OFS);
  wire       wr_div    = wr_fire & (awaddr_q == CLK_DIV_OFS);
  wire       wr_tune   = wr_fire & (awaddr_q == RC_TUNE_OFS);
  wire       wr_map    = wr_osc | wr_div | wr_tune;
  wire       lane_hi   = wr_osc & wstrb_q[1];
  wire       lane_lo   = wr_osc & wstrb_q[0];
  wire [7:0] hbyte     = wdata_q[15:8];
  wire [7:0] lbyte     = wdata_q[7:0];
  wire       hi_ok     = lane_hi & (hi_key_q == KEY_OPEN); // see RULE14
  wire       lo_ok     = lane_lo & (lo_key_q == KEY_OPEN); // see RULE15
  wire       frozen    = freeze_q & monitor_on; // see RULE1
  wire       new_wr    = hi_ok & sw_enabled & ~frozen;

  // unlock key sequencers: any other write breaks the sequence
  always_comb begin
    hi_key_d = hi_key_q;
    lo_key_d = lo_key_q;
    if (wr_fire) begin
      if (!lane_hi || hi_ok)                             hi_key_d = KEY_NONE; // see RULE24
      else if (hi_key_q == KEY_FIRST && hbyte == KEY_HI_B) hi_key_d = KEY_OPEN; // see RULE14
      else if (hbyte == KEY_HI_A)                         hi_key_d = KEY_FIRST;
      else                                                hi_key_d = KEY_NONE;
      if (!lane_lo || lo_ok)                             lo_key_d = KEY_NONE; // see RULE24
      else if (lo_key_q == KEY_FIRST && lbyte == KEY_LO_B) lo_key_d = KEY_OPEN; // see RULE15
      else if (lbyte == KEY_LO_A)                         lo_key_d = KEY_FIRST;
      else                                                lo_key_d = KEY_NONE;
    end
  end

  // source usage decode
  function automatic run_t uses(input src_t s);
    run_t r;
    r      = '0;
    r.fast_internal_rc  = (s == SRC_RC) | (s == SRC_RC_PLL) | (s == SRC_RC_DIV) | (s == SRC_LPFRC_DIV); // see RULE23
    r.pll  = (s == SRC_RC_PLL) | (s == SRC_PRI_PLL);
    r.primary_osc = (s == SRC_PRI) | (s == SRC_PRI_PLL);
    r.secondary_osc = (s == SRC_SEC);
    r.low_power_internal_rc = (s == SRC_LOW_POWER_INTERNAL_RC);
    return r;
  endfunction

  // switch sequencer decode
  wire  busy       = (state_q != SW_IDLE);
  run_t r_cur;
  run_t r_tgt;
  assign r_cur = uses(cur_q);
  assign r_tgt = uses(tgt_q);
  wire  same_src   = (new_q == cur_q);
  wire  sw_start   = (state_q == SW_IDLE) & req_q & ~same_src & sw_enabled;
  wire  sw_abort   = (state_q == SW_IDLE) & req_q & same_src; // see RULE16
  wire  pll_active = busy ? r_tgt.pll : r_cur.pll; // see RULE2
  wire  tgt_ready  = (~r_tgt.primary_osc | pin_s_q.ost_done) & (~r_tgt.pll | lock_q); // see RULE18
  wire  last_edge  = clk_edge & (cnt_q == TEN_CLKS - 4'h1); // see RULE19
  wire  req_set    = lo_ok & lbyte[REQ_BIT] & sw_enabled & ~frozen & ~busy; // see RULE6
  wire  cf_set     = pin_s_q.fail_det & monitor_on; // see RULE3
  wire  cf_clr     = sw_start | (lo_ok & ~lbyte[CF_BIT]); // see RULE17

  // switch sequencer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SW_IDLE;
      cnt_q   <= 4'h0;
      tgt_q   <= SRC_RC;
    end else if (!sw_enabled) begin
      state_q <= SW_IDLE; // see RULE12
    end else begin
      unique case (state_q)
        SW_IDLE: begin
          cnt_q <= 4'h0;
          if (sw_start) begin
            tgt_q   <= new_q;
            state_q <= SW_START;
          end
        end
        SW_START: if (tgt_ready) state_q <= SW_COUNT; // see RULE18
        SW_COUNT: begin
          if (clk_edge) cnt_q <= cnt_q + 4'h1;
          if (last_edge) state_q <= SW_DONE; // see RULE19
        end
        SW_DONE:  state_q <= SW_IDLE;
      endcase
    end
  end

  // oscillator control register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_q     <= SRC_RC_DIV;
      new_q     <= SRC_RC_DIV;
      freeze_q  <= 1'b0;
      lock_q    <= 1'b0;
      cf_q      <= 1'b0;
      drv_q     <= 1'b0;
      secondary_osc_en_q <= 1'b0;
      req_q     <= 1'b0;
      hi_key_q  <= KEY_NONE;
      lo_key_q  <= KEY_NONE;
    end else begin
      hi_key_q <= hi_key_d;
      lo_key_q <= lo_key_d;
      lock_q   <= sw_start ? 1'b0 : (pin_s_q.pll_lock & pll_active); // see RULE17
      if (cf_set)      cf_q <= 1'b1; // see RULE3
      else if (cf_clr) cf_q <= 1'b0;
      if (init_load) begin
        cur_q <= src_t'(pin_s_q.start_osc_cfg);
        new_q <= src_t'(pin_s_q.start_osc_cfg);
      end else if (!sw_enabled) begin
        cur_q <= src_t'(pin_s_q.start_osc_cfg); // see RULE13
      end else if (state_q == SW_DONE) begin
        cur_q <= tgt_q; // see RULE20
      end
      if (new_wr) new_q <= src_t'(hbyte[2:0]); // see RULE14
      if (lo_ok) begin
        freeze_q  <= freeze_q | lbyte[FREEZE_BIT];
        drv_q     <= lbyte[DRV_BIT];
        secondary_osc_en_q <= lbyte[SECONDARY_OSC_BIT]; // see RULE5
      end
      if (!sw_enabled || sw_abort || state_q == SW_DONE) req_q <= 1'b0; // see RULE20
      else if (req_set)                                  req_q <= 1'b1; // see RULE6
    end
  end

  // clock divider and tune registers; an interrupt beats a same-cycle write
  wire irq_recover = roi_q & pin_s_q.irq;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      roi_q       <= 1'b0;
      ratio_sel_q <= RATIO_RST; // see RULE8
      ratio_en_q  <= 1'b0;
      post_q      <= POST_RST; // see RULE10
      trim_q      <= 6'h00;
    end else begin
      if (wr_div && wstrb_q[1]) begin
        roi_q       <= wdata_q[ROI_BIT];
        ratio_sel_q <= wdata_q[RATIO_LSB +: 3];
        ratio_en_q  <= wdata_q[RATIO_EN];
        post_q      <= wdata_q[POST_LSB +: 3];
      end
      if (irq_recover) ratio_en_q <= 1'b0; // see RULE7
      if (wr_tune && wstrb_q[0]) trim_q <= wdata_q[TRIM_LSB +: 6]; // see RULE11
    end
  end

  // run requests: current, target while switching, and sources kept alive
  run_t run_d;
  always_comb begin
    run_d      = run_t'(r_cur | (busy ? r_tgt : run_t'('0))); // see RULE21
    run_d.secondary_osc = run_d.secondary_osc | secondary_osc_en_q;
    run_d.low_power_internal_rc = run_d.low_power_internal_rc | pin_s_q.low_power_internal_rc_keep | monitor_on;
  end

  // registered outputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_run         <= '0;
      ratio_code      <= 3'h0;
      rc_post_code    <= POST_RST;
      rc_post_active  <= 1'b0;
      secondary_osc_high_power <= 1'b0;
    end else begin
      osc_run         <= run_d;
      ratio_code      <= ratio_en_q ? ratio_sel_q : 3'h0; // see RULE9
      rc_post_code    <= post_q;
      rc_post_active  <= (cur_q == SRC_RC_DIV) | (cur_q == SRC_LPFRC_DIV); // see RULE10
      secondary_osc_high_power <= pin_s_q.secondary_osc_source_cfg & drv_q; // see RULE4
    end
  end

  assign cur_osc     = cur_q;
  assign switch_busy = req_q;
  assign rc_trim_out = trim_q;

  // read decode
  wire [31:0] osc_word = {16'h0000, 1'b0, cur_q, 1'b0, new_q, freeze_q, 1'b0, lock_q, 1'b0,
                          cf_q, drv_q, secondary_osc_en_q, req_q};
  wire [31:0] div_word = {16'h0000, roi_q, ratio_sel_q, ratio_en_q, post_q, 8'h00};
  wire [31:0] tun_word = {26'h0, trim_q};
  wire        rd_osc   = (bus_req.araddr == OSC_CTRL_OFS);
  wire        rd_div   = (bus_req.araddr == CLK_DIV_OFS);
  wire        rd_tun   = (bus_req.araddr == RC_TUNE_OFS);
  wire [31:0] rd_mux   = rd_osc ? osc_word : rd_div ? div_word : rd_tun ? tun_word : 32'h00000000;
  wire        aw_take  = bus_req.awvalid & bus_rsp.awready;
  wire        w_take   = bus_req.wvalid & bus_rsp.wready;
  wire        ar_take  = bus_req.arvalid & bus_rsp.arready;

  // bus slave: address and data taken in either order, one of each at a time
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= bus_req.awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q  <= bus_req.wdata;
        wstrb_q  <= bus_req.wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bus_req.bready) begin
        bvalid_q <= 1'b0;
      end
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= (rd_osc | rd_div | rd_tun) ? RESP_OKAY : RESP_SLVERR;
      end else if (bus_req.rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // bus answers
  always_comb begin
    bus_rsp         = '0;
    bus_rsp.awready = init_done & ~aw_held_q;
    bus_rsp.wready  = init_done & ~w_held_q;
    bus_rsp.bvalid  = bvalid_q;
    bus_rsp.bresp   = bresp_q;
    bus_rsp.arready = init_done & ~rvalid_q;
    bus_rsp.rvalid  = rvalid_q;
    bus_rsp.rdata   = rdata_q;
    bus_rsp.rresp   = rresp_q;
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_valid_start;
    state_q == SW_IDLE ##0 req_q ##0 !same_src ##0 sw_enabled;
  endsequence

  a_hi_key_gate: assert property ($past(init_done) && $changed(new_q) |-> $past(hi_ok)) // see RULE14
    else $error("new selection changed without upper unlock");
  a_lo_key_gate: assert property ($changed(secondary_osc_en_q) |-> $past(lo_ok)) // see RULE15
    else $error("secondary enable changed without lower unlock");
  a_freeze_hold: assert property (frozen && lane_hi |=> $stable(new_q)) // see RULE1
    else $error("frozen selection was modified");
  a_redundant_abort: assert property (sw_abort && sw_enabled |=> !req_q && state_q == SW_IDLE) // see RULE16
    else $error("redundant switch not aborted");
  a_start_clears: assert property (s_valid_start |=> !lock_q && state_q == SW_START) // see RULE17
    else $error("switch start did not clear lock");
  a_ten_edges: assert property ($rose(state_q == SW_DONE) |-> $past(cnt_q) == TEN_CLKS - 4'h1) // see RULE19
    else $error("changeover before ten new-clock cycles");
  a_done_copy: assert property (state_q == SW_DONE && sw_enabled |=> cur_q == $past(tgt_q) && !req_q) // see RULE20
    else $error("completion did not copy selection");
  a_disabled_hold: assert property (!sw_enabled |=> !req_q ##1 !req_q) // see RULE12
    else $error("request set while switching disabled");
  a_irq_recover: assert property (irq_recover |=> !ratio_en_q ##1 ratio_code == 3'h0) // see RULE7
    else $error("interrupt did not restore one-to-one ratio");
  a_ratio_force: assert property (!ratio_en_q |=> ratio_code == 3'h0) // see RULE9
    else $error("ratio not forced while disabled");

endmodule

/* osc_ctl_pkg.sv */
// osc_ctl_pkg: offsets, field positions, reset values, codes and carrier types
// for the oscillator switch and doze control block.
// assumes a 32-bit AXI4-Lite register bus with byte addresses of AW bits.
package osc_ctl_pkg;
  localparam int AW = 8;

  // register byte offsets
  localparam logic [AW-1:0] OSC_CTRL_OFS = 8'h00;
  localparam logic [AW-1:0] CLK_DIV_OFS  = 8'h04;
  localparam logic [AW-1:0] RC_TUNE_OFS  = 8'h08;

  // oscillator_control fields
  localparam int CUR_LSB    = 12;
  localparam int NEW_LSB    = 8;
  localparam int FREEZE_BIT = 7;
  localparam int LOCK_BIT   = 5;
  localparam int CF_BIT     = 3;
  localparam int DRV_BIT    = 2;
  localparam int SECONDARY_OSC_BIT   = 1;
  localparam int REQ_BIT    = 0;

  // clock_divider and rc_tune fields
  localparam int ROI_BIT    = 15;
  localparam int RATIO_LSB  = 12;
  localparam int RATIO_EN   = 11;
  localparam int POST_LSB   = 8;
  localparam int TRIM_LSB   = 0;

  // reset values and counts
  localparam logic [2:0] RATIO_RST   = 3'h3;
  localparam logic [2:0] POST_RST    = 3'h1;
  localparam logic [3:0] TEN_CLKS    = 4'hA;
  localparam logic [1:0] INIT_CYCLES = 2'h3;

  // unlock keys
  localparam logic [7:0] KEY_HI_A = 8'h78;
  localparam logic [7:0] KEY_HI_B = 8'h9A;
  localparam logic [7:0] KEY_LO_A = 8'h46;
  localparam logic [7:0] KEY_LO_B = 8'h57;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SRC_RC = 3'h0, SRC_RC_PLL = 3'h1, SRC_PRI = 3'h2, SRC_PRI_PLL = 3'h3,
    SRC_SEC = 3'h4, SRC_LOW_POWER_INTERNAL_RC = 3'h5, SRC_LPFRC_DIV = 3'h6, SRC_RC_DIV = 3'h7
  } src_t;

  typedef enum logic [1:0] {SW_IDLE = 2'b00, SW_START = 2'b01, SW_COUNT = 2'b11, SW_DONE = 2'b10} sw_state_t;
  typedef enum logic [1:0] {KEY_NONE = 2'b00, KEY_FIRST = 2'b01, KEY_OPEN = 2'b11} key_state_t;

  typedef struct packed {
    logic           awvalid;
    logic [AW-1:0]  awaddr;
    logic           wvalid;
    logic [31:0]    wdata;
    logic [3:0]     wstrb;
    logic           bready;
    logic           arvalid;
    logic [AW-1:0]  araddr;
    logic           rready;
  } axi_req_t;

  typedef struct packed {
    logic           awready;
    logic           wready;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           arready;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
  } axi_rsp_t;

  // raw levels from the oscillator side and configuration fuses
  typedef struct packed {
    logic           pll_lock;
    logic           ost_done;
    logic           new_clk;
    logic           fail_det;
    logic           irq;
    logic           low_power_internal_rc_keep;
    logic           switch_enable_cfg;
    logic           fail_safe_monitor_cfg;
    logic           secondary_osc_source_cfg;
    logic [2:0]     start_osc_cfg;
  } osc_pins_t;

  // oscillator run requests
  typedef struct packed {
    logic pll;
    logic primary_osc;
    logic secondary_osc;
    logic low_power_internal_rc;
    logic fast_internal_rc;
  } run_t;
endpackage

/* osc_switch_doze_tb.sv */
// osc_switch_doze_tb: self-checking bench for the oscillator switch and doze block.
// assumes the block alone on sys_clk, driven here as an AXI4-Lite master and pin source.
`timescale 1ns/1ps
module osc_switch_doze_tb
  import osc_ctl_pkg::*;
;
  logic       sys_clk;
  logic       reset_n;
  axi_req_t   bus_req;
  axi_rsp_t   bus_rsp;
  osc_pins_t  pins;
  src_t       cur_osc;
  run_t       osc_run;
  logic       secondary_osc_high_power;
  logic       switch_busy;
  logic [2:0] ratio_code;
  logic [2:0] rc_post_code;
  logic       rc_post_active;
  logic [5:0] rc_trim_out;
  logic [1:0] rsp;
  int         err_count;
  int         samples_checked;
  int         nc;

  // 100 MHz clock
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  osc_switch_doze i_dut (
    .sys_clk         (sys_clk),
    .reset_n         (reset_n),
    .bus_req         (bus_req),
    .bus_rsp         (bus_rsp),
    .pins            (pins),
    .cur_osc         (cur_osc),
    .osc_run         (osc_run),
    .secondary_osc_high_power (secondary_osc_high_power),
    .switch_busy     (switch_busy),
    .ratio_code      (ratio_code),
    .rc_post_code    (rc_post_code),
    .rc_post_active  (rc_post_active),
    .rc_trim_out     (rc_trim_out)
  );

  // slow target clock, one rising edge every six cycles, well under a quarter of sys_clk
  always @(posedge sys_clk) begin
    nc <= (nc == 2) ? 0 : nc + 1;
    if (nc == 2) pins.new_clk <= ~pins.new_clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk);
    bus_req.awvalid <= 1'b1;
    bus_req.awaddr  <= a;
    bus_req.wvalid  <= 1'b1;
    bus_req.wdata   <= d;
    bus_req.wstrb   <= s;
    bus_req.bready  <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (bus_req.awvalid && bus_rsp.awready) bus_req.awvalid <= 1'b0;
      if (bus_req.wvalid && bus_rsp.wready) bus_req.wvalid <= 1'b0;
      if (bus_rsp.bvalid === 1'b1) break;
    end
    rsp = bus_rsp.bresp;
    bus_req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_req.arvalid <= 1'b1;
    bus_req.araddr  <= a;
    bus_req.rready  <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (bus_req.arvalid && bus_rsp.arready) bus_req.arvalid <= 1'b0;
      if (bus_rsp.rvalid === 1'b1) break;
    end
    d = bus_rsp.rdata;
    rsp = bus_rsp.rresp;
    bus_req.rready <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    rd(a, d);
    chk({30'h0, rsp}, {30'h0, er}, "rresp");
    chk(d, exp, "rdata");
  endtask

  // key pair then the payload write, all on one byte lane of the control register
  task automatic keyed(input logic hi, input logic [7:0] v);
    logic [3:0] s;
    s = hi ? 4'h2 : 4'h1;
    wr(OSC_CTRL_OFS, {4{hi ? KEY_HI_A : KEY_LO_A}}, s);
    wr(OSC_CTRL_OFS, {4{hi ? KEY_HI_B : KEY_LO_B}}, s);
    wr(OSC_CTRL_OFS, {4{v}}, s);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wait_idle(input int max);
    int n;
    n = 0;
    while (switch_busy !== 1'b0 && n < max) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    test_done();
  end

  initial begin
    logic [3:0] c;
    reset_n = 1'b0;
    bus_req = '0;
    pins = '0;
    pins.start_osc_cfg = 3'h7;
    pins.secondary_osc_source_cfg = 1'b1;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // reset values and the unmapped place
    chk_rd(OSC_CTRL_OFS, 32'h0000_7700, RESP_OKAY);
    chk_rd(CLK_DIV_OFS, 32'h0000_3100, RESP_OKAY);
    chk_rd(RC_TUNE_OFS, 32'h0000_0000, RESP_OKAY);
    chk_rd(8'h0C, 32'h0000_0000, RESP_SLVERR);
    wr(8'h0C, 32'hFFFF_FFFF, 4'hF);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "bresp");
    chk({29'h0, ratio_code}, 32'h0, "ratio");
    chk({31'h0, rc_post_active}, 32'h1, "post act");
    // trim is six bits, minimum code, reserved bits stay 0
    wr(RC_TUNE_OFS, 32'hFFFF_FFE0, 4'hF);
    chk_rd(RC_TUNE_OFS, 32'h0000_0020, RESP_OKAY);
    chk({26'h0, rc_trim_out}, 32'h20, "trim");
    // every ratio and postscale code
    for (c = 4'h0; c < 4'h8; c++) begin
      wr(CLK_DIV_OFS, {16'h0, 1'b0, c[2:0], 1'b1, 3'h7 - c[2:0], 8'h00}, 4'hF);
      cyc(2);
      chk({29'h0, ratio_code}, {29'h0, c[2:0]}, "ratio");
      chk({29'h0, rc_post_code}, {29'h0, 3'h7 - c[2:0]}, "post");
    end
    wr(CLK_DIV_OFS, 32'h0000_5000, 4'hF);
    cyc(2);
    chk({29'h0, ratio_code}, 32'h0, "ratio off");
    // interrupt recovery on and off
    wr(CLK_DIV_OFS, 32'h0000_D800, 4'hF);
    pins.irq <= 1'b1;
    cyc(6);
    pins.irq <= 1'b0;
    chk({29'h0, ratio_code}, 32'h0, "irq recover");
    chk_rd(CLK_DIV_OFS, 32'h0000_D000, RESP_OKAY);
    wr(CLK_DIV_OFS, 32'h0000_5800, 4'hF);
    pins.irq <= 1'b1;
    cyc(6);
    pins.irq <= 1'b0;
    chk({29'h0, ratio_code}, 32'h5, "irq kept");
    // unkeyed and wrongly keyed control writes
    wr(OSC_CTRL_OFS, 32'h0000_0000, 4'h3);
    wr(OSC_CTRL_OFS, {4{KEY_HI_B}}, 4'h2);
    wr(OSC_CTRL_OFS, {4{KEY_HI_A}}, 4'h2);
    wr(OSC_CTRL_OFS, 32'h0000_0000, 4'h2);
    chk_rd(OSC_CTRL_OFS, 32'h0000_7700, RESP_OKAY);
    wr(OSC_CTRL_OFS, {4{KEY_LO_B}}, 4'h1);
    wr(OSC_CTRL_OFS, {4{KEY_LO_A}}, 4'h1);
    wr(OSC_CTRL_OFS, 32'h0000_0007, 4'h1);
    cyc(2);
    chk({31'h0, switch_busy}, 32'h0, "bad key");
    // switch to plain rc with secondary enabled and high drive
    keyed(1'b1, SRC_RC);
    chk_rd(OSC_CTRL_OFS, 32'h0000_7000, RESP_OKAY);
    keyed(1'b0, 8'h07);
    cyc(2);
    chk({31'h0, switch_busy}, 32'h1, "pending");
    chk({31'h0, osc_run.fast_internal_rc}, 32'h1, "target run");
    cyc(30);
    chk({31'h0, switch_busy}, 32'h1, "ten clocks");
    wait_idle(200);
    cyc(2);
    chk({29'h0, cur_osc}, 32'h0, "cur");
    chk({31'h0, rc_post_active}, 32'h0, "post act");
    chk({31'h0, secondary_osc_high_power}, 32'h1, "drive");
    chk({31'h0, osc_run.secondary_osc}, 32'h1, "secondary_osc run");
    chk({31'h0, osc_run.low_power_internal_rc}, 32'h1, "low_power_internal_rc kept");
    chk_rd(OSC_CTRL_OFS, 32'h0000_0006, RESP_OKAY);
    // same source again is dropped at once
    keyed(1'b0, 8'h07);
    wait_idle(4);
    chk({31'h0, switch_busy}, 32'h0, "redundant");
    chk({29'h0, cur_osc}, 32'h0, "cur kept");
    // rc with pll waits for lock
    keyed(1'b1, SRC_RC_PLL);
    keyed(1'b0, 8'h07);
    cyc(100);
    chk({31'h0, switch_busy}, 32'h1, "lock wait");
    chk({31'h0, osc_run.pll}, 32'h1, "pll run");
    chk_rd(OSC_CTRL_OFS, 32'h0000_0107, RESP_OKAY);
    pins.pll_lock <= 1'b1;
    wait_idle(200);
    cyc(4);
    chk({29'h0, cur_osc}, 32'h1, "cur pll");
    chk_rd(OSC_CTRL_OFS, 32'h0000_1126, RESP_OKAY);
    pins.fail_det <= 1'b1;
    cyc(4);
    pins.fail_det <= 1'b0;
    cyc(4);
    chk_rd(OSC_CTRL_OFS, 32'h0000_112E, RESP_OKAY);
    // back to plain rc: status cleared, pll stopped
    keyed(1'b1, SRC_RC);
    keyed(1'b0, 8'h0F);
    wait_idle(200);
    cyc(4);
    chk_rd(OSC_CTRL_OFS, 32'h0000_0006, RESP_OKAY);
    chk({31'h0, osc_run.pll}, 32'h0, "pll off");
    // frozen selection refuses a switch
    keyed(1'b1, SRC_PRI);
    keyed(1'b0, 8'h86);
    chk_rd(OSC_CTRL_OFS, 32'h0000_0286, RESP_OKAY);
    keyed(1'b0, 8'h87);
    cyc(8);
    chk({31'h0, switch_busy}, 32'h0, "frozen");
    chk({29'h0, cur_osc}, 32'h0, "frozen cur");
    keyed(1'b1, SRC_SEC);
    chk_rd(OSC_CTRL_OFS, 32'h0000_0286, RESP_OKAY);
    // switching disabled, digital secondary input
    pins.switch_enable_cfg <= 1'b1;
    pins.start_osc_cfg <= 3'h4;
    pins.secondary_osc_source_cfg <= 1'b0;
    do_reset();
    cyc(2);
    chk({29'h0, cur_osc}, 32'h4, "cfg cur");
    keyed(1'b1, SRC_RC);
    keyed(1'b0, 8'h05);
    cyc(4);
    chk({31'h0, switch_busy}, 32'h0, "disabled");
    chk({29'h0, cur_osc}, 32'h4, "disabled cur");
    chk({31'h0, secondary_osc_high_power}, 32'h0, "digital");
    test_done();
  end
endmodule
